/* File: shared/afs_pkg.sv */
// Constants, field layout and state codes shared by the amplifier fault supervisor.
// Assumes a 125 MHz core clock and an external serial-bus engine on the same clock.
package afs_pkg;

  localparam int CLK_HZ = 125_000_000;

  // Register offsets
  localparam logic [7:0] ADDR_CTRL_FREQ  = 8'h0a;
  localparam logic [7:0] ADDR_CTRL_DIAG  = 8'h0b;
  localparam logic [7:0] ADDR_THERM_STAT = 8'h13;
  localparam logic [7:0] ADDR_FAULT_CAUSE = 8'h14;
  localparam logic [7:0] ADDR_OP_STATE   = 8'h15;

  // Reset values
  localparam logic [7:0] RST_CTRL_FREQ   = 8'h0d;
  localparam logic [7:0] RST_CTRL_DIAG   = 8'h50;
  localparam logic [7:0] RST_THERM_STAT  = 8'h00;
  localparam logic [7:0] RST_FAULT_CAUSE = 8'h00;

  // Field positions
  localparam int FS_LSB           = 0;
  localparam int CLIPSEL_LSB      = 2;
  localparam int PHASE180_BIT     = 5;
  localparam int FOLD_TO_PIN_BIT  = 7;
  localparam int DC_SD_EN_BIT     = 4;
  localparam int TWEETER_MODE_BIT = 5;
  localparam int FOLD_BASE        = 1;
  localparam int OTSD_BASE        = 5;
  localparam int FC_UV            = 0;
  localparam int FC_OV            = 1;
  localparam int FC_OTW           = 2;
  localparam int FC_OC_BASE       = 3;
  localparam int FC_DC_BASE       = 5;
  localparam int FC_OTSD          = 7;

  typedef enum logic [1:0] {
    CS_TWEETER = 2'b00,
    CS_CLIP    = 2'b01,
    CS_HEAT    = 2'b10,
    CS_BOTH    = 2'b11
  } afs_clip_sel_t;

  localparam logic [1:0] FS_CODE_500 = 2'b00;
  localparam logic [1:0] FS_CODE_357 = 2'b10;
  localparam int FS_500_KHZ = 500;
  localparam int FS_417_KHZ = 417;
  localparam int FS_357_KHZ = 357;
  localparam int PER_W = 9;
  localparam logic [PER_W-1:0] PER_500 = PER_W'((CLK_HZ + FS_500_KHZ * 500) / (FS_500_KHZ * 1000));
  localparam logic [PER_W-1:0] PER_417 = PER_W'((CLK_HZ + FS_417_KHZ * 500) / (FS_417_KHZ * 1000));
  localparam logic [PER_W-1:0] PER_357 = PER_W'((CLK_HZ + FS_357_KHZ * 500) / (FS_357_KHZ * 1000));

  // Overcurrent timer: a cycle-by-cycle limit lasting this long becomes a latched fault
  localparam int OC_TIME_NS = 10_000;
  localparam int OC_CYCLES  = (OC_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int OC_CNT_W   = 11;
  localparam logic [OC_CNT_W-1:0] OC_LAST = OC_CNT_W'(OC_CYCLES - 1);

  typedef enum logic [2:0] {
    OP_STANDBY   = 3'b000,
    OP_FLOAT     = 3'b001,
    OP_MUTED     = 3'b010,
    OP_RAMP_UP   = 3'b011,
    OP_PLAY      = 3'b100,
    OP_RAMP_DOWN = 3'b101
  } afs_op_state_t;

  // Synchronised pin vector layout
  localparam int PIN_MUTE_N    = 0;
  localparam int PIN_STANDBY_N = 1;
  localparam int PIN_POR       = 2;
  localparam int PIN_UV        = 3;
  localparam int PIN_OV        = 4;
  localparam int PIN_OTW       = 5;
  localparam int PIN_RAMP_HIGH = 6;
  localparam int PIN_FOLD      = 7;
  localparam int PIN_OTSD      = 9;
  localparam int PIN_CLIP      = 11;
  localparam int PIN_CBC       = 13;
  localparam int PIN_DC        = 15;
  localparam int PIN_TWEET     = 17;
  localparam int PIN_COUNT     = 19;

endpackage : afs_pkg

/* File: shared/afs_link_if.sv */
// Carrier between the supervisor core, its pin synchroniser and its phase generator.
// Assumes all three sit on the same clock.
interface afs_link_if;
  import afs_pkg::*;

  logic [PIN_COUNT-1:0] level;
  logic [1:0]           fs_code;
  logic                 phase180;
  logic                 run;
  logic [1:0]           tick;

  modport sync_side  (output level);
  modport phase_side (input fs_code, phase180, run, output tick);
  modport core       (input level, tick, output fs_code, phase180, run);
endinterface : afs_link_if

/* File: logic/afs_pin_sync.sv */
// Two-flop synchroniser for every analog comparator and control pin.
// Assumes the raw pins are asynchronous to clk_in.
module afs_pin_sync
  import afs_pkg::*;
(
  input  wire logic                 clk_in,     // Core clock
  input  wire logic                 reset_n_in, // Synchronous reset, active low
  input  wire logic [PIN_COUNT-1:0] raw_in,     // Raw pin levels
  afs_link_if.sync_side             lk          // Synchronised levels
);

  logic [PIN_COUNT-1:0] stage1;
  logic [PIN_COUNT-1:0] stage2;

  // Reset to zero reads as standby and mute asserted, the safe side
  for (genvar i = 0; i < PIN_COUNT; i++)
  begin : g_bit
    always_ff @(posedge clk_in)
    begin
      if (!reset_n_in)
      begin
        stage1[i] <= 1'b0;
        stage2[i] <= 1'b0;
      end
      else
      begin
        stage1[i] <= raw_in[i];
        stage2[i] <= stage1[i];
      end
    end
  end

  assign lk.level = stage2;

endmodule : afs_pin_sync

/* File: logic/afs_phase_gen.sv */
// Switching period counter giving one start pulse per channel per period.
// Assumes the core holds run low while the outputs must not switch.
module afs_phase_gen
  import afs_pkg::*;
(
  input  wire logic clk_in,     // Core clock
  input  wire logic reset_n_in, // Synchronous reset, active low
  afs_link_if.phase_side lk     // Frequency, phase select and ticks
);

  logic [PER_W-1:0] cnt;
  logic [PER_W-1:0] next_cnt;
  logic [PER_W-1:0] period;
  logic [PER_W-1:0] offset;
  logic [1:0]       tick;
  logic [1:0]       next_tick;

  always_comb
  begin
    // The forbidden code falls back to the middle frequency instead of stalling
    unique case (lk.fs_code)
      FS_CODE_500: period = PER_500;
      FS_CODE_357: period = PER_357;
      default:     period = PER_417;
    endcase
    offset = lk.phase180 ? (period >> 1) : (period >> 3);
    next_cnt  = '0;
    next_tick = 2'b00;
    if (lk.run)
    begin
      next_cnt     = (cnt >= period - 1'b1) ? '0 : cnt + 1'b1;
      next_tick[0] = (next_cnt == '0);
      next_tick[1] = (next_cnt == offset);
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      cnt  <= '0;
      tick <= 2'b00;
    end
    else
    begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end

  assign lk.tick = tick;

endmodule : afs_phase_gen

/* File: logic/afs_supervisor.sv */
// Fault and operating-state supervisor for a two-channel switching amplifier.
// Assumes a serial-bus engine on clk_in presents single-cycle register strobes.
// How it works
// R01: Foldback per channel shown in status bits
// R02: Shutdown per channel shown in status bits
// R03: Status register reads zero after reset
// R04: Fault pin driven on automatic float/standby
// R05: Causes readable; supply-low forces standby, bus off
// R06: Warning pin source selectable: heat, clip, both
// R07: Tweeter detection also drives warning pin
// R08: Mute pin mutes all channels together
// R09: Host mutes over bus; pin for emergencies (no bus mute bit here; only the mute pin mutes)
// R10: Standby pin clears registers, floats bus
// R11: Channels switch with 45 or 180 offset
// R12: Host picks switching frequency by radio band
// R13: Current limit starts overcurrent timer, self-clears
// R14: State register follows mute ramp progress
// R15: Supply faults float, overheat latches standby
// R16: Channel overcurrent/dc faults float that channel
// R17: Host sets warning source in control bits
// R18: Host sets frequency code, never eleven
// R19: Host sets 180 phase bit, else 45
module afs_supervisor
  import afs_pkg::*;
(
  input  wire logic       clk_in,                      // Core clock, 125 MHz
  input  wire logic       reset_n_in,                  // Synchronous reset, active low
  input  wire logic       mute_n_in,                   // Mute pin, active low
  input  wire logic       standby_n_in,                // Standby pin, active low
  input  wire logic       por_low_in,                  // Supply below power-on threshold
  input  wire logic       undervolt_in,                // Supply undervoltage comparator
  input  wire logic       overvolt_in,                 // Supply overvoltage comparator
  input  wire logic       overtemp_warning_in,         // Overtemperature warning comparator
  input  wire logic       mute_ramp_capacitor_high_in, // Mute capacitor ramp at top
  input  wire logic [1:0] foldback_in,                 // Thermal foldback per channel
  input  wire logic [1:0] ot_shutdown_in,              // Overtemperature shutdown per channel
  input  wire logic [1:0] clip_in,                     // Output clipping per channel
  input  wire logic [1:0] cycle_by_cycle_limit_in,     // Load current limit hit per channel
  input  wire logic [1:0] dc_detect_in,                // Output dc detected per channel
  input  wire logic [1:0] tweeter_detect_in,           // Tweeter found per channel
  input  wire logic [7:0] reg_addr_in,                 // Register offset
  input  wire logic       reg_wr_in,                   // Register write strobe
  input  wire logic       reg_rd_in,                   // Register read strobe
  input  wire logic [7:0] reg_wdata_in,                // Register write data
  output logic      [7:0] reg_rdata_out,               // Register read data
  output logic            reg_ack_out,                 // Access answered, one cycle
  output logic            bus_enable_out,              // Bus pins live; low floats them
  output logic            fault_n_out,                 // Fault pin drive level, low
  output logic            fault_oe_out,                // Fault pin enable, high drives
  output logic            clip_heat_warning_n_out,     // Warning pin drive level, low
  output logic            clip_heat_warning_oe_out,    // Warning pin enable, high drives
  output logic            standby_out,                 // Device held in standby
  output logic            mute_all_out,                // All channels muted
  output logic [1:0]      outputs_floating_state_out,  // Channel output stage floating
  output logic [1:0]      current_limit_out,           // Channel current being limited
  output logic [1:0]      channel_start_out            // Channel switching period start
);

  afs_link_if lk ();
  logic [PIN_COUNT-1:0] raw_pins;

  always_comb
  begin
    raw_pins                  = '0;
    raw_pins[PIN_MUTE_N]      = mute_n_in;
    raw_pins[PIN_STANDBY_N]   = standby_n_in;
    raw_pins[PIN_POR]         = por_low_in;
    raw_pins[PIN_UV]          = undervolt_in;
    raw_pins[PIN_OV]          = overvolt_in;
    raw_pins[PIN_OTW]         = overtemp_warning_in;
    raw_pins[PIN_RAMP_HIGH]   = mute_ramp_capacitor_high_in;
    raw_pins[PIN_FOLD +: 2]   = foldback_in;
    raw_pins[PIN_OTSD +: 2]   = ot_shutdown_in;
    raw_pins[PIN_CLIP +: 2]   = clip_in;
    raw_pins[PIN_CBC +: 2]    = cycle_by_cycle_limit_in;
    raw_pins[PIN_DC +: 2]     = dc_detect_in;
    raw_pins[PIN_TWEET +: 2]  = tweeter_detect_in;
  end

  afs_pin_sync u_sync (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .raw_in     (raw_pins),
    .lk         (lk.sync_side)
  );

  afs_phase_gen u_phase (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .lk         (lk.phase_side)
  );

  logic       mute_n_s;
  logic       ramp_high_s;
  logic [1:0] fold_s;
  logic [1:0] otsd_s;
  logic [1:0] clip_s;
  logic [1:0] cbc_s;
  logic [1:0] dc_s;
  logic [1:0] tweet_s;
  logic       bus_live;
  logic       soft_clear;

  assign mute_n_s    = lk.level[PIN_MUTE_N];
  assign ramp_high_s = lk.level[PIN_RAMP_HIGH];
  assign fold_s      = lk.level[PIN_FOLD +: 2];
  assign otsd_s      = lk.level[PIN_OTSD +: 2];
  assign clip_s      = lk.level[PIN_CLIP +: 2];
  assign cbc_s       = lk.level[PIN_CBC +: 2];
  assign dc_s        = lk.level[PIN_DC +: 2];
  assign tweet_s     = lk.level[PIN_TWEET +: 2];
  // Supply below threshold or standby pin both kill the bus and wipe its registers
  assign bus_live    = lk.level[PIN_STANDBY_N] & ~lk.level[PIN_POR];  // [R05] [R10]
  assign soft_clear  = ~bus_live;                                      // [R10]

  // ---- Registers
  afs_op_state_t state;
  afs_op_state_t next_state;
  logic [7:0]    ctrl_freq;
  logic [7:0]    next_ctrl_freq;
  logic [7:0]    ctrl_diag;
  logic [7:0]    next_ctrl_diag;
  logic [7:0]    therm_stat;
  logic [7:0]    next_therm_stat;
  logic [7:0]    cause;
  logic [7:0]    next_cause;
  logic [7:0]    cause_set;
  logic [1:0]    oc_trip;
  logic [1:0]    dc_trip;
  logic [1:0]    chan_float;
  logic          global_float;
  logic          otsd_latched;
  logic          monitoring;
  logic          wr_hit;

  assign global_float = cause[FC_UV] | cause[FC_OV];                   // [R15]
  assign otsd_latched = cause[FC_OTSD];                                // [R15]
  assign monitoring   = (state != OP_STANDBY);
  assign wr_hit       = reg_wr_in & bus_live;

  for (genvar ch = 0; ch < 2; ch++)
  begin : g_chan
    logic [OC_CNT_W-1:0] oc_cnt;
    logic [OC_CNT_W-1:0] next_oc_cnt;

    always_comb
    begin
      next_oc_cnt = '0;
      if (cbc_s[ch] && monitoring)
        next_oc_cnt = (oc_cnt == OC_LAST) ? oc_cnt : oc_cnt + 1'b1;     // [R13]
    end

    always_ff @(posedge clk_in)
    begin
      if (!reset_n_in)
        oc_cnt <= '0;
      else
        oc_cnt <= next_oc_cnt;
    end

    assign oc_trip[ch]    = cbc_s[ch] & monitoring & (oc_cnt == OC_LAST);            // [R13] [R16]
    assign dc_trip[ch]    = dc_s[ch] & monitoring & ctrl_diag[DC_SD_EN_BIT];         // [R16]
    assign chan_float[ch] = cause[FC_OC_BASE + ch] | cause[FC_DC_BASE + ch];         // [R16]
  end

  always_comb
  begin
    cause_set                   = '0;
    cause_set[FC_UV]            = lk.level[PIN_UV] & monitoring;
    cause_set[FC_OV]            = lk.level[PIN_OV] & monitoring;
    cause_set[FC_OC_BASE +: 2]  = oc_trip;
    cause_set[FC_DC_BASE +: 2]  = dc_trip;
    cause_set[FC_OTSD]          = |otsd_s;
    next_ctrl_freq  = ctrl_freq;
    next_ctrl_diag  = ctrl_diag;
    next_therm_stat = '0;
    next_therm_stat[FOLD_BASE +: 2] = fold_s;                          // [R01]
    next_therm_stat[OTSD_BASE +: 2] = otsd_s;                          // [R02]
    // Writing ones clears latched causes; a cause still present sets again at once
    next_cause = (cause & ~(wr_hit && reg_addr_in == ADDR_FAULT_CAUSE ? reg_wdata_in : 8'h00)) | cause_set;
    next_cause[FC_OTW] = lk.level[PIN_OTW] & monitoring;               // [R15]
    if (wr_hit && reg_addr_in == ADDR_CTRL_FREQ)
      next_ctrl_freq = reg_wdata_in;
    if (wr_hit && reg_addr_in == ADDR_CTRL_DIAG)
      next_ctrl_diag = reg_wdata_in;
    if (soft_clear)
    begin
      next_ctrl_freq  = RST_CTRL_FREQ;                                 // [R10]
      next_ctrl_diag  = RST_CTRL_DIAG;
      next_therm_stat = RST_THERM_STAT;                                // [R03]
      next_cause      = RST_FAULT_CAUSE;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      ctrl_freq  <= RST_CTRL_FREQ;
      ctrl_diag  <= RST_CTRL_DIAG;
      therm_stat <= RST_THERM_STAT;                                    // [R03]
      cause      <= RST_FAULT_CAUSE;
    end
    else
    begin
      ctrl_freq  <= next_ctrl_freq;
      ctrl_diag  <= next_ctrl_diag;
      therm_stat <= next_therm_stat;
      cause      <= next_cause;
    end
  end

  // ---- Operating state; ramps only advance when the mute capacitor arrives
  always_comb
  begin
    next_state = state;
    if (soft_clear || otsd_latched)
      next_state = OP_STANDBY;                                         // [R15] [R05]
    else if (global_float)
      next_state = OP_FLOAT;                                           // [R15]
    else
    begin
      unique case (state)
        OP_STANDBY,
        OP_FLOAT:     next_state = OP_MUTED;
        OP_MUTED:     next_state = mute_n_s ? OP_RAMP_UP : OP_MUTED;   // [R08]
        OP_RAMP_UP:
          if (!mute_n_s)
            next_state = OP_RAMP_DOWN;
          else if (ramp_high_s)
            next_state = OP_PLAY;                                      // [R14]
        OP_PLAY:      next_state = mute_n_s ? OP_PLAY : OP_RAMP_DOWN;  // [R08]
        OP_RAMP_DOWN:
          if (mute_n_s)
            next_state = OP_RAMP_UP;
          else if (!ramp_high_s)
            next_state = OP_MUTED;                                     // [R14]
        default:      next_state = OP_STANDBY;
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
      state <= OP_STANDBY;
    else
      state <= next_state;
  end

  assign lk.fs_code  = ctrl_freq[FS_LSB +: 2];
  assign lk.phase180 = ctrl_freq[PHASE180_BIT];                        // [R11]
  assign lk.run      = (state != OP_STANDBY) && (state != OP_FLOAT);   // [R11]

  // ---- Pin and bus outputs, registered except the tied-low pin drive levels
  logic       warn_raw;
  logic       next_fault_oe;
  logic       next_warn_oe;
  logic [7:0] next_rdata;
  logic       next_ack;
  logic       heat_cond;
  logic       clip_cond;

  always_comb
  begin
    heat_cond = lk.level[PIN_OTW] | (ctrl_freq[FOLD_TO_PIN_BIT] & |fold_s);
    clip_cond = |clip_s;
    unique case (afs_clip_sel_t'(ctrl_freq[CLIPSEL_LSB +: 2]))         // [R06]
      CS_TWEETER: warn_raw = 1'b0;
      CS_CLIP:    warn_raw = clip_cond;
      CS_HEAT:    warn_raw = heat_cond;
      CS_BOTH:    warn_raw = clip_cond | heat_cond;
    endcase
    next_warn_oe  = monitoring & (warn_raw | (ctrl_diag[TWEETER_MODE_BIT] & |tweet_s));  // [R07]
    // The supply-low case keeps the fault pin low even though the bus is gone
    next_fault_oe = lk.level[PIN_POR] | global_float | otsd_latched | (|chan_float);  // [R04] [R05]
    next_ack      = bus_live & (reg_rd_in | reg_wr_in);
    next_rdata    = 8'h00;
    if (bus_live && reg_rd_in)
    begin
      unique case (reg_addr_in)
        ADDR_CTRL_FREQ:   next_rdata = ctrl_freq;
        ADDR_CTRL_DIAG:   next_rdata = ctrl_diag;
        ADDR_THERM_STAT:  next_rdata = therm_stat;                     // [R01] [R02]
        ADDR_FAULT_CAUSE: next_rdata = cause;                          // [R05]
        ADDR_OP_STATE:    next_rdata = {5'h00, state};                 // [R14]
        default:          next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      fault_oe_out               <= 1'b0;
      clip_heat_warning_oe_out   <= 1'b0;
      reg_rdata_out              <= 8'h00;
      reg_ack_out                <= 1'b0;
      bus_enable_out             <= 1'b0;
      standby_out                <= 1'b1;
      mute_all_out               <= 1'b1;
      outputs_floating_state_out <= 2'b11;
      current_limit_out          <= 2'b00;
      channel_start_out          <= 2'b00;
    end
    else
    begin
      fault_oe_out               <= next_fault_oe;
      clip_heat_warning_oe_out   <= next_warn_oe;
      reg_rdata_out              <= next_rdata;
      reg_ack_out                <= next_ack;
      bus_enable_out             <= bus_live;                          // [R10]
      standby_out                <= (state == OP_STANDBY);
      mute_all_out               <= (state != OP_PLAY);                // [R08]
      outputs_floating_state_out <= {2{(state == OP_STANDBY) | global_float}} | chan_float;  // [R16]
      current_limit_out          <= cbc_s & {2{monitoring}};           // [R13]
      channel_start_out          <= lk.tick;                           // [R11]
    end
  end

  assign fault_n_out             = 1'b0;
  assign clip_heat_warning_n_out = 1'b0;

  // ---- Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_supply_gone;
    !bus_live;
  endsequence

  sequence s_oc_expires;
    cbc_s[0] && monitoring && bus_live && g_chan[0].oc_cnt == OC_LAST;
  endsequence

  a_status_cleared: assert property (s_supply_gone |=> therm_stat == 8'h00 && cause == 8'h00)  // [R03]
    else $error("status not cleared while bus is down");
  a_foldback_bit: assert property (bus_live && fold_s[1] |=> therm_stat[FOLD_BASE + 1])  // [R01]
    else $error("channel 2 foldback not reported");
  a_shutdown_standby: assert property (bus_live && otsd_s[0] |=> therm_stat[OTSD_BASE] ##2 standby_out)  // [R02]
    else $error("overtemperature shutdown not reported or not in standby");
  a_por_fault_pin: assert property (lk.level[PIN_POR] |-> ##1 fault_oe_out && !bus_enable_out)  // [R05]
    else $error("supply-low fault pin or bus state wrong");
  a_oc_latches: assert property (s_oc_expires |=> cause[FC_OC_BASE] ##1 fault_oe_out && outputs_floating_state_out[0])  // [R16]
    else $error("overcurrent timer expiry did not float channel");
  a_uv_float: assert property (bus_live && monitoring && lk.level[PIN_UV] |-> ##[1:3] (&outputs_floating_state_out))  // [R15]
    else $error("undervoltage did not float outputs");
  a_mute_ramp_down: assert property (state == OP_PLAY && !mute_n_s && bus_live && !global_float && !otsd_latched
                                     |=> state == OP_RAMP_DOWN ##1 mute_all_out)  // [R08]
    else $error("mute pin did not start ramp down");
  a_ramp_waits: assert property (state == OP_RAMP_UP && mute_n_s && !ramp_high_s && bus_live && !global_float
                                 && !otsd_latched |=> state == OP_RAMP_UP)  // [R14]
    else $error("ramp left before capacitor reached top");
  a_clip_select: assert property (ctrl_freq[CLIPSEL_LSB +: 2] == CS_CLIP && clip_cond && monitoring
                                  |=> clip_heat_warning_oe_out)  // [R06]
    else $error("clip not shown on warning pin");
  a_standby_defaults: assert property (s_supply_gone |=> ctrl_freq == RST_CTRL_FREQ && ctrl_diag == RST_CTRL_DIAG)  // [R10]
    else $error("standby did not restore control defaults");

endmodule : afs_supervisor

/* File: testbench/afs_host_model.sv */
// Host model issuing single-cycle register strobes to the supervisor.
// Assumes callers enter rw just after a falling edge of clk_in.
module afs_host_model
(
  input  wire logic       clk_in,   // Core clock
  input  wire logic [7:0] rdata_in, // Read data
  input  wire logic       ack_in,   // Access answered
  output logic      [7:0] addr_out, // Register offset
  output logic            wr_out,   // Write strobe
  output logic            rd_out,   // Read strobe
  output logic      [7:0] wdata_out // Write data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {addr_out, wr_out, rd_out, wdata_out} = '0;
  // Band and phase choices go over these writes, muting over the pin; code 11 is never sent
  task automatic rw(input logic w, input logic [7:0] a, d, output logic [7:0] q, output logic ok);
    int n;
    {addr_out, wdata_out, wr_out, rd_out} = {a, d, w, !w};
    @(posedge clk_in);
    @(negedge clk_in);
    // Released lines show a changed pattern so a late sample cannot pass
    {addr_out, wdata_out, wr_out, rd_out} = {~a, ~d, 2'b00};
    ok = 0;
    q = 8'h00;
    for (n = 0; n < 4 && !ok; n++)
    begin
      @(posedge clk_in);
      ok = (ack_in === 1'b1);
      q = rdata_in;
    end
  endtask : rw
endmodule : afs_host_model

/* File: testbench/afs_supervisor_tb_top.sv */
// Self-checking bench for the fault supervisor, table rows then hand cases.
// Assumes the host model drives all register strobes.
`define CHK(nm, e, s) begin total_checks++; if ((s) !== (e)) begin error_cnt++; $display("[ERR] %s exp %h got %h", nm, e, s); end end
module afs_supervisor_tb_top;
  import afs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [1:0] f; logic [1:0] t; logic [7:0] e;} afs_row_t;
  localparam afs_row_t ROWS [7] = '{'{2'b00, 2'b00, 8'h00}, '{2'b01, 2'b00, 8'h02}, '{2'b10, 2'b00, 8'h04},
    '{2'b11, 2'b00, 8'h06}, '{2'b00, 2'b01, 8'h20}, '{2'b00, 2'b10, 8'h40}, '{2'b11, 2'b11, 8'h66}};
  logic       clk_in, reset_n_in, mute_n_in, standby_n_in, por_low_in, uv, overtemp_warning, ramp_hi, ok, ov, fn, wn;
  logic [1:0] fold, otsd, clip, cbc, tweet, flt, climit, start, dc;
  logic [7:0] addr, wdata, rdata, q;
  logic       wr, rd, ack, bus_en, f_oe, w_oe, sb, mute_all;
  int         error_cnt, total_checks, n, m;
  afs_supervisor i_dut (.clk_in, .reset_n_in, .mute_n_in, .standby_n_in, .por_low_in, .undervolt_in(uv),
    .overvolt_in(ov), .overtemp_warning_in(overtemp_warning), .mute_ramp_capacitor_high_in(ramp_hi), .foldback_in(fold),
    .ot_shutdown_in(otsd), .clip_in(clip), .cycle_by_cycle_limit_in(cbc), .dc_detect_in(dc),
    .tweeter_detect_in(tweet), .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .reg_ack_out(ack), .bus_enable_out(bus_en), .fault_n_out(fn), .fault_oe_out(f_oe),
    .clip_heat_warning_n_out(wn), .clip_heat_warning_oe_out(w_oe), .standby_out(sb), .mute_all_out(mute_all),
    .outputs_floating_state_out(flt), .current_limit_out(climit), .channel_start_out(start));
  afs_host_model i_host (.clk_in, .rdata_in(rdata), .ack_in(ack), .addr_out(addr), .wr_out(wr), .rd_out(rd),
    .wdata_out(wdata));
  initial
  begin
    clk_in = 0;
    forever #4 clk_in = ~clk_in;
  end
  task automatic cyc(int k); repeat (k) @(negedge clk_in); endtask : cyc
  task automatic acc(logic w, logic [7:0] a, d); i_host.rw(w, a, d, q, ok); @(negedge clk_in); endtask : acc
  task automatic rdc(string nm, logic [7:0] a, e); acc(0, a, 8'h00); `CHK(nm, {1'b1, e}, {ok, q}) endtask : rdc
  task automatic wt(int b, output int k);
    k = 0;
    do @(posedge clk_in); while (start[b] !== 1'b1 && ++k < 999);
  endtask : wt
  task automatic ph(logic [7:0] code, int gap, int per);
    acc(1, ADDR_CTRL_FREQ, code);
    wt(0, n); wt(0, n); wt(1, n); wt(0, m);
    `CHK("phase_gap", gap, n + 1)
    `CHK("period", per, n + m + 2)
    @(negedge clk_in);
  endtask : ph
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  initial
  begin
    {reset_n_in, mute_n_in, por_low_in, uv, overtemp_warning, ramp_hi, fold, otsd, clip, cbc, tweet, ov, dc} = '0;
    standby_n_in = 1;
    cyc(6);
    reset_n_in = 1;
    cyc(6);
    rdc("therm_rst", ADDR_THERM_STAT, RST_THERM_STAT);
    acc(1, ADDR_THERM_STAT, 8'hff);
    rdc("therm_ro", ADDR_THERM_STAT, 8'h00);
    foreach (ROWS[i])
    begin
      {fold, otsd} = {ROWS[i].f, ROWS[i].t};
      cyc(6);
      rdc("therm_stat", ADDR_THERM_STAT, ROWS[i].e);
      `CHK("fault_otsd", |ROWS[i].t, f_oe)
      {fold, otsd} = '0;
      cyc(6);
      acc(1, ADDR_FAULT_CAUSE, 8'hff);
      cyc(4);
    end
    for (int s = 0; s < 8; s++)
    begin
      acc(1, ADDR_CTRL_FREQ, 8'h01 | 8'((s >> 1) << 2));
      {clip, overtemp_warning} = s[0] ? 3'b000 : 3'b010;
      overtemp_warning = s[0];
      cyc(6);
      `CHK("warn_sel", (s == 2) || (s == 5) || (s > 5), w_oe)
      {clip, overtemp_warning} = '0;
    end
    acc(1, ADDR_CTRL_FREQ, 8'h01);
    acc(1, ADDR_CTRL_DIAG, 8'h70);
    tweet = 2'b10;
    cyc(6);
    `CHK("warn_tweet", 1'b1, w_oe)
    tweet = 0;
    mute_n_in = 1;
    cyc(6);
    rdc("op_up", ADDR_OP_STATE, 8'h03);
    ramp_hi = 1;
    cyc(6);
    rdc("op_play", ADDR_OP_STATE, 8'h04);
    `CHK("unmuted", 1'b0, mute_all)
    mute_n_in = 0;
    cyc(6);
    rdc("op_down", ADDR_OP_STATE, 8'h05);
    ramp_hi = 0;
    cyc(6);
    `CHK("muted", 1'b1, mute_all)
    ph(8'h20, 125, 250);
    ph(8'h22, 175, 350);
    ph(8'h01, 37, 300);
    standby_n_in = 0;
    cyc(6);
    `CHK("sb_bus", 1'b0, bus_en)
    `CHK("sb_state", 1'b1, sb)
    acc(0, ADDR_CTRL_FREQ, 8'h00);
    `CHK("sb_noack", 1'b0, ok)
    `CHK("pin_lvl", 2'b00, {fn, wn})
    standby_n_in = 1;
    cyc(6);
    rdc("freq_cleared", ADDR_CTRL_FREQ, RST_CTRL_FREQ);
    por_low_in = 1;
    cyc(6);
    `CHK("por_bus", 1'b0, bus_en)
    `CHK("por_fault", 1'b1, f_oe)
    por_low_in = 0;
    uv = 1;
    cyc(8);
    `CHK("uv_float", 2'b11, flt)
    `CHK("uv_fault", 1'b1, f_oe)
    uv = 0;
    cyc(6);
    rdc("uv_cause", ADDR_FAULT_CAUSE, 8'h01);
    `CHK("uv_latch", 2'b11, flt)
    acc(1, ADDR_FAULT_CAUSE, 8'h01);
    cyc(6);
    `CHK("uv_clear", 2'b00, flt)
    cbc = 2'b01;
    cyc(6);
    `CHK("climit", 2'b01, climit)
    cyc(OC_CYCLES);
    `CHK("oc_float", 2'b01, flt)
    `CHK("oc_fault", 1'b1, f_oe)
    cbc = 0;
    cyc(6);
    `CHK("climit_off", 2'b00, climit)
    rdc("oc_cause", ADDR_FAULT_CAUSE, 8'h08);
    {ov, dc} = 3'b110;
    cyc(6);
    rdc("ov_dc_cause", ADDR_FAULT_CAUSE, 8'h4a);
    `CHK("dc_float", 2'b11, flt)
    conclude();
  end
  initial
  begin
    repeat (20000) @(posedge clk_in);
    error_cnt++;
    conclude();
  end
endmodule : afs_supervisor_tb_top
